// ==== design/rle_pkg.sv ====
// constants and carrier types of the receive-lane escape and error report block
package rle_pkg;

    // line levels, written {linePos, lineNeg}
    localparam logic [1:0] LINE_STOP   = 2'h3;
    localparam logic [1:0] LINE_MARK1  = 2'h2;  // also low-power request; escape request is mark-0 after bridge
    localparam logic [1:0] LINE_MARK0  = 2'h1;  // also high-speed request
    localparam logic [1:0] LINE_BRIDGE = 2'h0;

    // escape entry commands, first received bit in the msb
    localparam logic [7:0] CMD_LPDT      = 8'he1;
    localparam logic [7:0] CMD_ULPS      = 8'h1e;
    localparam logic [7:0] CMD_TRIG_RST  = 8'h62;
    localparam logic [7:0] CMD_TRIG_UNK3 = 8'h5d;
    localparam logic [7:0] CMD_TRIG_UNK4 = 8'h21;
    localparam logic [7:0] CMD_TRIG_UNK5 = 8'ha0;

    // trigger output codes
    localparam logic [3:0] TRIG_RST_CODE  = 4'h1;
    localparam logic [3:0] TRIG_UNK3_CODE = 4'h4;
    localparam logic [3:0] TRIG_UNK4_CODE = 4'h8;
    localparam logic [3:0] TRIG_UNK5_CODE = 4'h8;
    localparam logic [3:0] TRIG_NONE      = 4'h0;

    // byte assembly
    localparam int         BYTE_BITS     = 8;
    localparam logic [3:0] BIT_CNT_FULL  = 4'h8;
    localparam logic [3:0] BIT_CNT_RST   = 4'h0;
    localparam logic [7:0] BYTE_RST      = 8'h00;

    // escape data buffer
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;

    // high-speed start of transmission
    localparam logic [7:0] SYNC_LEADER    = 8'hb8;
    localparam logic [3:0] SYNC_SOFT_DIST = 4'h1;
    localparam logic [1:0] DDR_EDGES_HALF = 2'h2;  // ddr rising edges per byte-clock half
    localparam logic [1:0] DDR_CNT_RST    = 2'h0;

    typedef enum logic [11:0] {
        ST_INIT  = 12'h001,  // waiting for stop after reset or re-init
        ST_STOP  = 12'h002,
        ST_HSRQ  = 12'h004,
        ST_HS    = 12'h008,
        ST_LPRQ  = 12'h010,
        ST_LPBR  = 12'h020,
        ST_ESCRQ = 12'h040,
        ST_CMD   = 12'h080,
        ST_LPDT  = 12'h100,
        ST_ULPS  = 12'h200,
        ST_TRIG  = 12'h400,
        ST_WAIT  = 12'h800   // turnaround or fault, wait for stop
    } rle_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rle_esc_data_t;

    typedef struct packed {
        logic sotSoft;   // one byte-clock period
        logic sotSync;   // one byte-clock period
        logic esc;       // held until next line change
        logic syncEsc;   // held until next line change
        logic control;   // held until next line change
    } rle_err_t;

    localparam rle_err_t ERR_RST = '{default: 1'b0};
    localparam rle_esc_data_t ESC_DATA_RST = '{valid: 1'b0, data: 8'h00};

endpackage : rle_pkg

// ==== design/rle_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module rle_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,      // core clock
    input  wire logic             sys_rst,  // async reset, active high
    input  wire logic             inValid,  // write request
    output logic                  inReady,  // space available
    input  wire logic [WIDTH-1:0] inData,   // write word
    output logic                  outValid, // word available
    input  wire logic             outReady, // read request
    output logic      [WIDTH-1:0] outData   // head word
);
    localparam int AW = $clog2(DEPTH);
    // the count is one bit wider than the pointers so full and empty stay apart
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
    } rle_fifo_st_t;

    rle_fifo_st_t st_ff;
    rle_fifo_st_t nxt_st;
    logic         doPush;
    logic         doPop;

    assign inReady  = (st_ff.count != CNT_FULL);
    assign outValid = (st_ff.count != '0);
    assign outData  = st_ff.mem[st_ff.rdPtr];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    always_comb begin
        nxt_st = st_ff;
        if (doPush) begin
            nxt_st.mem[st_ff.wrPtr] = inData;
            nxt_st.wrPtr = (st_ff.wrPtr == AW'(DEPTH - 1)) ? '0 : st_ff.wrPtr + 1'b1;
        end
        if (doPop) begin
            nxt_st.rdPtr = (st_ff.rdPtr == AW'(DEPTH - 1)) ? '0 : st_ff.rdPtr + 1'b1;
        end
        case ({doPush, doPop})
            2'b10: nxt_st.count = st_ff.count + 1'b1;
            2'b01: nxt_st.count = st_ff.count - 1'b1;
            default: nxt_st.count = st_ff.count;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : rle_fifo

// ==== design/rle_rx_lane.sv ====
// receive data lane: escape decoding, escape data delivery and error report
`timescale 1ns/1ps
module rle_rx_lane
    import rle_pkg::*;
(
    input  wire logic                   clk,         // 25 MHz core clock
    input  wire logic                   sys_rst,     // async reset, active high
    input  wire logic                   linePos,     // low-power level of line_pos
    input  wire logic                   lineNeg,     // low-power level of line_neg
    input  wire logic                   reInit,      // force lane re-initialisation
    input  wire logic                   ddrClkIn,    // sampled high-speed ddr clock
    input  wire logic                   hsClkActive, // clock lane is in high-speed mode
    input  wire logic                   hsActive,    // high-speed reception active
    input  wire logic [7:0]             hsLeader,    // first byte seen after sot
    output logic                        escClk,      // recovered escape clock
    output logic                        lpdtMode,    // low-power data receive mode
    output logic                        ulpsMode,    // ultra-low-power state
    output logic      [3:0]             trigOut,     // received trigger bits
    output rle_pkg::rle_esc_data_t      escOut,      // escape byte and valid
    output logic                        byteClk,     // divided high-speed byte clock
    output logic                        syncHs,      // sync observed pulse
    output rle_pkg::rle_err_t           errOut       // error flags
);
    import rle_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        rle_state_t    fsm;
        logic [1:0]    prevLine;
        logic          escClk;
        logic [3:0]    bitCnt;
        logic [7:0]    shiftReg;
        logic [3:0]    trig;
        rle_esc_data_t esc;
        rle_err_t      err;
        logic [1:0]    ddrCnt;
        logic          ddrPrev;
        logic          byteClk;
        logic          syncDone;
        logic          syncHs;
    } rle_lane_st_t;

    localparam rle_lane_st_t LANE_RST = '{
        fsm:      ST_INIT,
        prevLine: LINE_STOP,
        escClk:   1'b0,
        bitCnt:   BIT_CNT_RST,
        shiftReg: BYTE_RST,
        trig:     TRIG_NONE,
        esc:      ESC_DATA_RST,
        err:      ERR_RST,
        ddrCnt:   DDR_CNT_RST,
        ddrPrev:  1'b0,
        byteClk:  1'b0,
        syncDone: 1'b0,
        syncHs:   1'b0
    };

    rle_lane_st_t st_ff;
    rle_lane_st_t nxt_st;

    logic [1:0] line;
    logic       lineChg;
    logic       markTick;
    logic       spaceTick;
    logic       bitTick;
    logic       markBit;
    logic       pushValid;
    logic [7:0] pushData;
    logic       pushReady;
    logic       popValid;
    logic       popReady;
    logic [7:0] popData;

    assign line      = {linePos, lineNeg};
    assign lineChg   = (line != st_ff.prevLine);
    // a bit is a mark entered from bridge; the space after it ends the bit
    assign markTick  = (st_ff.prevLine == LINE_BRIDGE)
                       && (line == LINE_MARK1 || line == LINE_MARK0);
    assign spaceTick = (line == LINE_BRIDGE) && lineChg;
    // a bit is committed on its space, so the mark-1 that leads into stop never counts
    assign bitTick   = spaceTick
                       && (st_ff.prevLine == LINE_MARK1 || st_ff.prevLine == LINE_MARK0);
    assign markBit   = (st_ff.prevLine == LINE_MARK1);

    function automatic logic [3:0] bitDistance(input logic [7:0] a, input logic [7:0] b);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < BYTE_BITS; i++) begin
            n = n + {3'h0, a[i] ^ b[i]};
        end
        return n;
    endfunction : bitDistance

    ////////////////////////////////////////////////////////////////////////////
    // escape byte buffer; drained one word per escape bit, so it stalls while
    // the lines sit idle and only empties as the transmitter keeps clocking

    rle_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_esc_fifo (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushData),
        .outValid (popValid),
        .outReady (popReady),
        .outData  (popData)
    );

    assign pushData = {markBit, st_ff.shiftReg[7:1]};
    assign pushValid = (st_ff.fsm == ST_LPDT) && bitTick
                       && (st_ff.bitCnt == BIT_CNT_FULL - 4'h1) && !reInit;
    assign popReady  = markTick && !reInit;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st = st_ff;
        nxt_st.prevLine = line;

        // held errors drop on a line change unless set again below
        if (lineChg) begin
            nxt_st.err.esc     = 1'b0;
            nxt_st.err.syncEsc = 1'b0;
            nxt_st.err.control = 1'b0;
        end

        // escape clock trails the line by two cycles, so escOut has settled before it rises
        nxt_st.escClk = 1'b0;
        if (st_ff.fsm == ST_CMD || st_ff.fsm == ST_LPDT || st_ff.fsm == ST_ESCRQ) begin
            nxt_st.escClk = st_ff.prevLine[1] ^ st_ff.prevLine[0];
        end

        // escape data out: a word stands from one mark to the next
        if (popReady) begin
            nxt_st.esc.valid = popValid;
            nxt_st.esc.data  = popValid ? popData : st_ff.esc.data;
        end

        case (st_ff.fsm)
            ST_INIT: begin
                if (line == LINE_STOP) begin
                    nxt_st.fsm = ST_STOP;
                end
            end
            ST_STOP: begin
                nxt_st.trig = TRIG_NONE;
                case (line)
                    LINE_MARK0:  nxt_st.fsm = ST_HSRQ;
                    LINE_MARK1:  nxt_st.fsm = ST_LPRQ;
                    LINE_BRIDGE: begin
                        nxt_st.err.control = 1'b1;
                        nxt_st.fsm         = ST_WAIT;
                    end
                    default:     nxt_st.fsm = ST_STOP;
                endcase
            end
            ST_HSRQ: begin
                case (line)
                    LINE_BRIDGE: nxt_st.fsm = ST_HS;
                    LINE_MARK0:  nxt_st.fsm = ST_HSRQ;
                    LINE_STOP: begin
                        nxt_st.err.control = 1'b1;
                        nxt_st.fsm         = ST_STOP;
                    end
                    default: begin
                        nxt_st.err.control = 1'b1;
                        nxt_st.fsm         = ST_WAIT;
                    end
                endcase
            end
            ST_LPRQ: begin
                case (line)
                    LINE_BRIDGE: nxt_st.fsm = ST_LPBR;
                    LINE_MARK1:  nxt_st.fsm = ST_LPRQ;
                    LINE_STOP: begin
                        nxt_st.err.control = 1'b1;
                        nxt_st.fsm         = ST_STOP;
                    end
                    default: begin
                        nxt_st.err.control = 1'b1;
                        nxt_st.fsm         = ST_WAIT;
                    end
                endcase
            end
            ST_LPBR: begin
                case (line)
                    LINE_MARK0:  nxt_st.fsm = ST_ESCRQ;
                    LINE_MARK1:  nxt_st.fsm = ST_WAIT;  // turnaround, handled elsewhere
                    LINE_BRIDGE: nxt_st.fsm = ST_LPBR;
                    default: begin
                        nxt_st.err.control = 1'b1;
                        nxt_st.fsm         = ST_STOP;
                    end
                endcase
            end
            ST_ESCRQ: begin
                nxt_st.bitCnt   = BIT_CNT_RST;
                nxt_st.shiftReg = BYTE_RST;
                case (line)
                    LINE_BRIDGE: nxt_st.fsm = ST_CMD;
                    LINE_MARK0:  nxt_st.fsm = ST_ESCRQ;
                    LINE_STOP: begin
                        nxt_st.err.control = 1'b1;
                        nxt_st.fsm         = ST_STOP;
                    end
                    default: begin
                        nxt_st.err.control = 1'b1;
                        nxt_st.fsm         = ST_WAIT;
                    end
                endcase
            end
            ST_CMD: begin
                if (line == LINE_STOP) begin
                    nxt_st.err.control = 1'b1;
                    nxt_st.fsm         = ST_STOP;
                end else if (bitTick) begin
                    // command bits arrive msb first
                    nxt_st.shiftReg = {st_ff.shiftReg[6:0], markBit};
                    nxt_st.bitCnt   = st_ff.bitCnt + 4'h1;
                    if (st_ff.bitCnt == BIT_CNT_FULL - 4'h1) begin
                        nxt_st.bitCnt   = BIT_CNT_RST;
                        nxt_st.shiftReg = BYTE_RST;
                        case ({st_ff.shiftReg[6:0], markBit})
                            CMD_LPDT: nxt_st.fsm = ST_LPDT;
                            CMD_ULPS: nxt_st.fsm = ST_ULPS;
                            CMD_TRIG_RST: begin
                                nxt_st.trig = TRIG_RST_CODE;
                                nxt_st.fsm  = ST_TRIG;
                            end
                            CMD_TRIG_UNK3: begin
                                nxt_st.trig = TRIG_UNK3_CODE;
                                nxt_st.fsm  = ST_TRIG;
                            end
                            CMD_TRIG_UNK4: begin
                                nxt_st.trig = TRIG_UNK4_CODE;
                                nxt_st.fsm  = ST_TRIG;
                            end
                            CMD_TRIG_UNK5: begin
                                nxt_st.trig = TRIG_UNK5_CODE;
                                nxt_st.fsm  = ST_TRIG;
                            end
                            default: begin
                                nxt_st.err.esc = 1'b1;
                                nxt_st.fsm     = ST_WAIT;
                            end
                        endcase
                    end
                end
            end
            ST_LPDT: begin
                if (line == LINE_STOP) begin
                    if (st_ff.bitCnt != BIT_CNT_RST) begin
                        nxt_st.err.syncEsc = 1'b1;
                    end
                    nxt_st.bitCnt = BIT_CNT_RST;
                    nxt_st.fsm    = ST_STOP;
                end else if (bitTick) begin
                    // data bits arrive lsb first
                    nxt_st.shiftReg = {markBit, st_ff.shiftReg[7:1]};
                    nxt_st.bitCnt   = st_ff.bitCnt + 4'h1;
                    if (st_ff.bitCnt == BIT_CNT_FULL - 4'h1) begin
                        nxt_st.bitCnt = BIT_CNT_RST;
                        // no throttle exists upstream, so an overrun is a lost byte
                        if (!pushReady) begin
                            nxt_st.err.syncEsc = 1'b1;
                        end
                    end
                end
            end
            ST_ULPS, ST_TRIG, ST_HS, ST_WAIT: begin
                if (line == LINE_STOP) begin
                    nxt_st.trig = TRIG_NONE;
                    nxt_st.fsm  = ST_STOP;
                end
            end
            default: nxt_st.fsm = ST_INIT;
        endcase

        ////////////////////////////////////////////////////////////////////////
        // byte clock: ddr clock divided by four, stopped outside high-speed

        nxt_st.ddrPrev = ddrClkIn;
        if (!hsClkActive) begin
            nxt_st.ddrCnt  = DDR_CNT_RST;
            nxt_st.byteClk = 1'b0;
        end else if (ddrClkIn && !st_ff.ddrPrev) begin
            if (st_ff.ddrCnt == DDR_EDGES_HALF - 2'h1) begin
                nxt_st.ddrCnt  = DDR_CNT_RST;
                nxt_st.byteClk = !st_ff.byteClk;
            end else begin
                nxt_st.ddrCnt = st_ff.ddrCnt + 2'h1;
            end
        end

        // start-of-transmission check, once per burst on a byte-clock rise
        if (nxt_st.byteClk && !st_ff.byteClk) begin
            nxt_st.syncHs      = 1'b0;
            nxt_st.err.sotSoft = 1'b0;
            nxt_st.err.sotSync = 1'b0;
            if (hsActive && !st_ff.syncDone) begin
                nxt_st.syncDone = 1'b1;
                if (bitDistance(hsLeader, SYNC_LEADER) > SYNC_SOFT_DIST) begin
                    nxt_st.err.sotSync = 1'b1;
                end else begin
                    nxt_st.syncHs      = 1'b1;
                    nxt_st.err.sotSoft = (hsLeader != SYNC_LEADER);
                end
            end
        end
        if (!hsActive && !(nxt_st.byteClk && !st_ff.byteClk)) begin
            nxt_st.syncDone = 1'b0;
        end
        if (!hsClkActive) begin
            nxt_st.syncHs      = 1'b0;
            nxt_st.err.sotSoft = 1'b0;
            nxt_st.err.sotSync = 1'b0;
        end

        // re-init drops every escape mode, trigger and held error
        if (reInit) begin
            nxt_st.fsm         = ST_INIT;
            nxt_st.trig        = TRIG_NONE;
            nxt_st.esc         = ESC_DATA_RST;
            nxt_st.escClk      = 1'b0;
            nxt_st.bitCnt      = BIT_CNT_RST;
            nxt_st.err.esc     = 1'b0;
            nxt_st.err.syncEsc = 1'b0;
            nxt_st.err.control = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= LANE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; held error flags move with line state, not with escClk or
    // byteClk, so the consumer must bring them into its own domain

    assign escClk   = st_ff.escClk;
    assign lpdtMode = (st_ff.fsm == ST_LPDT);
    assign ulpsMode = (st_ff.fsm == ST_ULPS);
    assign trigOut  = st_ff.trig;
    assign escOut   = st_ff.esc;
    assign byteClk  = st_ff.byteClk;
    assign syncHs   = st_ff.syncHs;
    assign errOut   = st_ff.err;

endmodule : rle_rx_lane

// ==== sim/rle_lane_tx.sv ====
// remote transmitting lane: drives the two low-power line levels
`timescale 1ns/1ps
module rle_lane_tx (
    input  wire logic clk,     // core clock
    output logic      linePos, // line_pos level
    output logic      lineNeg  // line_neg level
);
    int hold = 1;
    initial {linePos, lineNeg} = 2'h3;
    // hold above one stretches every level, as a slow transmitter would
    task automatic put(input logic [1:0] v);
        repeat (hold) @(posedge clk);
        #1 {linePos, lineNeg} = v;
    endtask : put
    task automatic mark(input logic b);
        put(b ? 2'h2 : 2'h1);
        put(2'h0);
    endtask : mark
    task automatic entry(input logic [7:0] cmd);
        put(2'h2);
        put(2'h0);
        put(2'h1);
        put(2'h0);
        for (int i = 7; i >= 0; i--) mark(cmd[i]);
    endtask : entry
    task automatic bits(input logic [7:0] d, input int n);
        for (int i = 0; i < n; i++) mark(d[i]);
    endtask : bits
    task automatic stop();
        put(2'h2);
        put(2'h3);
    endtask : stop
endmodule : rle_lane_tx

// ==== sim/rle_rx_lane_monitor.sv ====
// assertion checker for the receive lane mode and error outputs
`timescale 1ns/1ps
module rle_rx_lane_monitor
    import rle_pkg::*;
(
    input wire logic              clk,         // core clock
    input wire logic              sys_rst,     // async reset
    input wire logic              linePos,     // line level
    input wire logic              lineNeg,     // line level
    input wire logic              reInit,      // re-init request
    input wire logic              hsClkActive, // clock lane fast
    input wire logic              lpdtMode,    // data mode
    input wire logic              ulpsMode,    // low-power state
    input wire logic [3:0]        trigOut,     // trigger bits
    input wire logic              byteClk,     // byte clock
    input wire logic              syncHs,      // sync pulse
    input wire rle_pkg::rle_err_t errOut       // error flags
);
    logic [1:0] ln;
    assign ln = {linePos, lineNeg};
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_stopClr; ln == 2'h3 |=> !lpdtMode && !ulpsMode && trigOut == 4'h0; endproperty
    a_stopClr: assert property (p_stopClr) else $error("mode kept past stop");
    property p_trigCode; trigOut inside {4'h0, 4'h1, 4'h4, 4'h8}; endproperty
    a_trigCode: assert property (p_trigCode) else $error("bad trigger code");
    property p_escHold; errOut.esc && $stable(ln) && !reInit |=> errOut.esc; endproperty
    a_escHold: assert property (p_escHold) else $error("escape error dropped");
    property p_ctlHold; errOut.control && $stable(ln) && !reInit |=> errOut.control; endproperty
    a_ctlHold: assert property (p_ctlHold) else $error("control error dropped");
    property p_reInit; reInit |=> !lpdtMode && !ulpsMode && trigOut == 4'h0 && errOut[2:0] == 3'h0;
    endproperty
    a_reInit: assert property (p_reInit) else $error("re-init left state");
    property p_byteIdle; !hsClkActive |=> !byteClk; endproperty
    a_byteIdle: assert property (p_byteIdle) else $error("byte clock without lane");
    property p_syncPulse; $rose(syncHs) |-> $rose(byteClk); endproperty
    a_syncPulse: assert property (p_syncPulse) else $error("sync off byte edge");
    property p_softPair; errOut.sotSoft |-> syncHs && !errOut.sotSync; endproperty
    a_softPair: assert property (p_softPair) else $error("soft error without sync");
    c_lpdt: cover property ($rose(lpdtMode));
    c_sync: cover property ($rose(syncHs));
    c_soft: cover property (errOut.sotSoft);
endmodule : rle_rx_lane_monitor
////////////////////////////////////////
bind rle_rx_lane rle_rx_lane_monitor mon (.clk, .sys_rst, .linePos, .lineNeg, .reInit,
    .hsClkActive, .lpdtMode, .ulpsMode, .trigOut, .byteClk, .syncHs, .errOut);

// ==== sim/test_rle_rx_lane.sv ====
// self-checking bench for the receive lane escape and error report block
`timescale 1ns/1ps
module test_rle_rx_lane;
    import rle_pkg::*;
    typedef struct packed {logic [7:0] cmd; logic lp; logic ul; logic [3:0] tr; logic er;} rle_row_t;
    logic clk, sys_rst, linePos, lineNeg, reInit, ddrClkIn, hsClkActive, hsActive;
    logic escClk, lpdtMode, ulpsMode, byteClk, syncHs;
    logic [7:0] hsLeader;
    logic [3:0] trigOut;
    rle_esc_data_t escOut;
    rle_err_t errOut;
    logic [5:0] seen;
    logic [7:0] got[$];
    int n_fail = 0, checks_done = 0, cycles = 0;
    rle_row_t rows [7] = '{'{CMD_LPDT, 1'b1, 1'b0, 4'h0, 1'b0},
        '{CMD_ULPS, 1'b0, 1'b1, 4'h0, 1'b0}, '{CMD_TRIG_RST, 1'b0, 1'b0, 4'h1, 1'b0},
        '{CMD_TRIG_UNK3, 1'b0, 1'b0, 4'h4, 1'b0}, '{CMD_TRIG_UNK4, 1'b0, 1'b0, 4'h8, 1'b0},
        '{CMD_TRIG_UNK5, 1'b0, 1'b0, 4'h8, 1'b0}, '{8'h55, 1'b0, 1'b0, 4'h0, 1'b1}};
    rle_lane_tx tx (.clk, .linePos, .lineNeg);
    rle_rx_lane dut (.clk, .sys_rst, .linePos, .lineNeg, .reInit, .ddrClkIn, .hsClkActive,
        .hsActive, .hsLeader, .escClk, .lpdtMode, .ulpsMode, .trigOut, .escOut, .byteClk,
        .syncHs, .errOut);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] act);
        checks_done++;
        if (act !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, act);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // pulses are short, so flags seen during the burst are gathered in seen
    task automatic burst(input logic [7:0] lead, input logic [2:0] exp);
        tick(4);
        seen = '0;
        hsLeader = lead;
        hsClkActive = 1'b1;
        hsActive = 1'b1;
        for (int i = 0; i < 24; i++) begin
            tick(2);
            ddrClkIn = ~ddrClkIn;
        end
        hsActive = 1'b0;
        hsClkActive = 1'b0;
        chk("sot flags", {5'h0, exp}, {5'h0, seen[2:0]});
    endtask : burst
    ////////////////////////////////////////
    always @(posedge clk) begin
        seen <= seen | {errOut.esc, errOut.syncEsc, errOut.control, syncHs, errOut[4:3]};
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end
    always @(posedge escClk) if (escOut.valid === 1'b1) got.push_back(escOut.data);
    initial begin
        {sys_rst, reInit, ddrClkIn, hsClkActive, hsActive, hsLeader, seen} = {5'h10, 8'h00, 6'h00};
        tick(4);
        sys_rst = 1'b0;
        tick(3);
        foreach (rows[i]) begin
            seen = '0;
            tx.entry(rows[i].cmd);
            tick(1);
            chk("lpdt mode", {7'h0, rows[i].lp}, {7'h0, lpdtMode});
            chk("ulps mode", {7'h0, rows[i].ul}, {7'h0, ulpsMode});
            chk("trigger", {4'h0, rows[i].tr}, {4'h0, trigOut});
            chk("escape error", {7'h0, rows[i].er}, {7'h0, errOut.esc});
            tx.stop();
            tick(1);
            chk("idle modes", 8'h00, {5'h0, lpdtMode, ulpsMode, |trigOut});
        end
        tx.hold = 2;
        tx.entry(CMD_LPDT);
        tx.bits(8'h96, 8);
        tx.bits(8'h3c, 8);
        tx.stop();
        tx.hold = 1;
        tick(2);
        chk("byte count", 8'h02, 8'(got.size()));
        chk("clean end sync error", 8'h00, {7'h0, errOut.syncEsc});
        foreach (got[i]) chk("escape byte", i ? 8'h3c : 8'h96, got[i]);
        seen = '0;
        tx.entry(CMD_LPDT);
        tx.bits(8'h05, 3);
        tx.stop();
        tick(2);
        chk("partial byte", 8'h01, {7'h0, seen[4]});
        seen = '0;
        tx.put(2'h2);
        tx.put(2'h3);
        tick(2);
        chk("control error", 8'h01, {7'h0, seen[3]});
        reInit = 1'b1;
        tick(3);
        reInit = 1'b0;
        tick(2);
        tx.entry(CMD_ULPS);
        tick(1);
        chk("ulps after reinit", 8'h01, {7'h0, ulpsMode});
        tx.stop();
        burst(SYNC_LEADER, 3'h4);
        burst(SYNC_LEADER ^ 8'h01, 3'h6);
        burst(~SYNC_LEADER, 3'h1);
        summarize();
    end
endmodule : test_rle_rx_lane
